// ### ptu_pkg.sv
`default_nettype none
package ptu_pkg;
    // ------------------------------------------------------------
    // Cause bit positions, highest priority at bit 0.
    // ------------------------------------------------------------
    localparam int PTU_NCAUSE = 15;
    localparam int C_IC_BUS = 0;
    localparam int C_DC_BUS = 1;
    localparam int C_EXT_INT = 2;
    localparam int C_FWATCH = 3;
    localparam int C_FMISS = 4;
    localparam int C_FPERM = 5;
    localparam int C_SOFTBP = 6;
    localparam int C_BADBUN = 7;
    localparam int C_DWATCH = 8;
    localparam int C_MISALIGN = 9;
    localparam int C_CR_UNMAP = 10;
    localparam int C_CR_DENY = 11;
    localparam int C_DMISS = 12;
    localparam int C_DPERM = 13;
    localparam int C_SIDE_TO = 14;
    // Causes that carry the faulting data address.
    localparam logic [PTU_NCAUSE-1:0] DADDR_CAUSES = 15'h3f00;

    // ------------------------------------------------------------
    // Status word layout and reset.
    // ------------------------------------------------------------
    localparam int SW_USER = 0;
    localparam int SW_IRQ_EN = 1;
    localparam int SW_DWATCH_EN = 8;
    localparam int SW_FWATCH_EN = 9;
    localparam logic [31:0] SW_RESET = 32'h0000_0000;
    localparam logic [31:0] SW_WR_MASK = 32'h0000_13f3;
    localparam logic [31:0] SW_TRAP_CLR = 32'h0000_0303;

    // ------------------------------------------------------------
    // Register byte offsets on the bus.
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SAVED_SW = 8'h04;
    localparam logic [7:0] OFS_SAVED_RESUME_ADDR = 8'h08;
    localparam logic [7:0] OFS_OLDER_SW = 8'h0c;
    localparam logic [7:0] OFS_OLDER_PC = 8'h10;
    localparam logic [7:0] OFS_HANDLER = 8'h14;
    localparam logic [7:0] OFS_CAUSE = 8'h18;
    localparam logic [7:0] OFS_DADDR = 8'h1c;
    localparam logic [7:0] OFS_CONFIG = 8'h20;
    localparam int CFG_MISALIGN_OK = 0;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffc;

    // Cycles during which younger bundles are cancelled after a redirect.
    localparam logic [1:0] REFILL_CYCLES = 2'h3;
endpackage
`default_nettype wire

// ### ptu_prio.sv
`timescale 1ns/100ps
`default_nettype none
module ptu_prio
    import ptu_pkg::*;
(
    input wire logic [PTU_NCAUSE-1:0] req_i,
    output logic [PTU_NCAUSE-1:0] win_o,
    output logic any_o
);
    logic [PTU_NCAUSE:0] seen;

    // ------------------------------------------------------------
    // Lowest set bit wins; a prefix chain blocks all later bits.
    // ------------------------------------------------------------
    assign seen[0] = 1'b0;
    genvar i;
    generate
        for (i = 0; i < PTU_NCAUSE; i++)
        begin : g_bit
            assign win_o[i] = req_i[i] & ~seen[i];
            assign seen[i+1] = seen[i] | req_i[i];
        end
    endgenerate
    assign any_o = seen[PTU_NCAUSE];
endmodule
`default_nettype wire

// ### ptu_daddr.sv
`timescale 1ns/100ps
`default_nettype none
module ptu_daddr
    import ptu_pkg::*;
(
    input wire logic [PTU_NCAUSE-1:0] win_i,
    input wire logic [31:0] data_addr_i,
    output logic [31:0] value_o
);
    // ------------------------------------------------------------
    // Pass the data address only for data-side causes, else zero.
    // ------------------------------------------------------------
    assign value_o = (|(win_i & DADDR_CAUSES)) ? data_addr_i : REG_RESET;
endmodule
`default_nettype wire

// ### ptu_trap_unit.sv
// Notes on behaviour
// - Older bundles commit; younger change nothing.
// - Trap point is start of faulting bundle.
// - Redirect fetch to handler entry address.
// - Cancel trapping bundle and all younger.
// - Traps serviced in order, one at once.
// - Record only the highest priority exception.
// - Save status, bundle address, set cause.
// - Clear user, irq, watch enables on entry.
// - Data address saved for six causes, else zero.
// - Return restores status, address, refills saves.
// - External interrupt is cause bit two.
// - Lower bit number means higher priority.
// - Instruction bus fault bit 0, data bit 1.
// - Fetch watch 3, soft break 6, data 8.
// - Fetch region miss 4, permission 5.
// - Bad bundle or user privileged op: 7.
// - Misaligned access without support sets 9.
// - Control register unmapped 10, user store 11.
// - Data region miss 12, permission 13.
// - Side interface timeout sets bit 14.
// - Status bits 0,1,8,9 reset to zero.
`timescale 1ns/100ps
`default_nettype none
module ptu_trap_unit
    import ptu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic bundle_valid_i,
    input wire logic [31:0] current_bundle_addr_i,
    input wire logic rfi_op_i,
    input wire logic icache_bus_fault_i,
    input wire logic dcache_bus_fault_i,
    input wire logic ext_irq_i,
    input wire logic fetch_watch_hit_i,
    input wire logic fetch_region_miss_i,
    input wire logic fetch_perm_fault_i,
    input wire logic soft_bp_hit_i,
    input wire logic bad_bundle_i,
    input wire logic priv_op_i,
    input wire logic data_watch_hit_i,
    input wire logic misaligned_i,
    input wire logic ctlreg_unmapped_i,
    input wire logic ctlreg_store_i,
    input wire logic data_region_miss_i,
    input wire logic data_perm_fault_i,
    input wire logic side_iface_timeout_i,
    input wire logic [31:0] data_addr_i,
    output logic commit_o,
    output logic cancel_o,
    output logic redirect_o,
    output logic [31:0] redirect_addr_o,
    output logic [31:0] status_o
);
    logic [31:0] status;
    logic [31:0] saved_status;
    logic [31:0] saved_resume_addr;
    logic [31:0] older_status;
    logic [31:0] older_resume_addr;
    logic [31:0] handler_entry_addr;
    logic [31:0] trap_cause_reg;
    logic [31:0] trap_data_addr;
    logic [31:0] config_reg;
    logic [1:0] squash_cnt;
    logic squash;
    logic [PTU_NCAUSE-1:0] cause_vec;
    logic [PTU_NCAUSE-1:0] win;
    logic any_cause;
    logic take_trap;
    logic do_rfi;
    logic [31:0] next_daddr;
    logic [31:0] wmask;
    logic bus_wr;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Cause collection.
    // ------------------------------------------------------------

    // Each source maps to its fixed cause bit.
    assign cause_vec[C_IC_BUS] = icache_bus_fault_i;
    assign cause_vec[C_DC_BUS] = dcache_bus_fault_i;
    assign cause_vec[C_EXT_INT] = ext_irq_i & status[SW_IRQ_EN];
    assign cause_vec[C_FWATCH] = fetch_watch_hit_i & status[SW_FWATCH_EN];
    assign cause_vec[C_FMISS] = fetch_region_miss_i;
    assign cause_vec[C_FPERM] = fetch_perm_fault_i;
    assign cause_vec[C_SOFTBP] = soft_bp_hit_i;
    assign cause_vec[C_BADBUN] = bad_bundle_i | (priv_op_i & status[SW_USER]);
    assign cause_vec[C_DWATCH] = data_watch_hit_i & status[SW_DWATCH_EN];
    assign cause_vec[C_MISALIGN] = misaligned_i & ~config_reg[CFG_MISALIGN_OK];
    assign cause_vec[C_CR_UNMAP] = ctlreg_unmapped_i;
    assign cause_vec[C_CR_DENY] = ctlreg_store_i & status[SW_USER];
    assign cause_vec[C_DMISS] = data_region_miss_i;
    assign cause_vec[C_DPERM] = data_perm_fault_i;
    assign cause_vec[C_SIDE_TO] = side_iface_timeout_i;

    // Fixed priority pick of one winner.
    ptu_prio u_prio (
        .req_i(cause_vec),
        .win_o(win),
        .any_o(any_cause)
    );

    // Faulting data address for the winning cause.
    ptu_daddr u_daddr (
        .win_i(win),
        .data_addr_i(data_addr_i),
        .value_o(next_daddr)
    );

    // ------------------------------------------------------------
    // Trap decision and bundle fate.
    // ------------------------------------------------------------

    // A bundle in the refill window is younger than a redirect and never counts.
    assign squash = (squash_cnt != 2'h0);
    assign take_trap = bundle_valid_i & ~squash & any_cause;
    assign do_rfi = bundle_valid_i & ~squash & rfi_op_i & ~any_cause;
    assign commit_o = bundle_valid_i & ~squash & ~any_cause;
    assign cancel_o = bundle_valid_i & (squash | any_cause);

    // Refill window counter; one trap at a time in bundle order.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            squash_cnt <= 2'h0;
        else if (take_trap || do_rfi)
            squash_cnt <= REFILL_CYCLES;
        else if (squash)
            squash_cnt <= squash_cnt - 2'h1;
    end

    // Redirect pulse and target for the fetch unit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            redirect_o <= 1'b0;
            redirect_addr_o <= REG_RESET;
        end
        else
        begin
            redirect_o <= take_trap | do_rfi;
            if (take_trap)
                redirect_addr_o <= handler_entry_addr;
            else if (do_rfi)
                redirect_addr_o <= saved_resume_addr;
        end
    end

    // ------------------------------------------------------------
    // Architectural trap state.
    // ------------------------------------------------------------

    // Byte-lane mask of a bus write; it lands at the acknowledging edge.
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign bus_wr = cyc_i & stb_i & we_i & ack_o;

    // Status word: trap and return take precedence over software.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status <= SW_RESET;
        else if (take_trap)
            status <= status & ~SW_TRAP_CLR;
        else if (do_rfi)
            status <= saved_status;
        else if (bus_wr && adr_i == OFS_STATUS)
            status <= (status & ~(wmask & SW_WR_MASK)) | (dat_i & wmask & SW_WR_MASK);
    end
    assign status_o = status;

    // Saved copies and their older generation.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            saved_status <= REG_RESET;
            saved_resume_addr <= REG_RESET;
            older_status <= REG_RESET;
            older_resume_addr <= REG_RESET;
        end
        else if (take_trap)
        begin
            saved_status <= status;
            saved_resume_addr <= current_bundle_addr_i & PC_ALIGN_MASK;
            older_status <= saved_status;
            older_resume_addr <= saved_resume_addr;
        end
        else if (do_rfi)
        begin
            saved_status <= older_status;
            saved_resume_addr <= older_resume_addr;
        end
        else if (bus_wr)
        begin
            if (adr_i == OFS_SAVED_SW)
                saved_status <= (saved_status & ~wmask) | (dat_i & wmask);
            if (adr_i == OFS_SAVED_RESUME_ADDR)
                saved_resume_addr <= ((saved_resume_addr & ~wmask) | (dat_i & wmask)) & PC_ALIGN_MASK;
            if (adr_i == OFS_OLDER_SW)
                older_status <= (older_status & ~wmask) | (dat_i & wmask);
            if (adr_i == OFS_OLDER_PC)
                older_resume_addr <= ((older_resume_addr & ~wmask) | (dat_i & wmask)) & PC_ALIGN_MASK;
        end
    end

    // Cause and data address records of the last trap.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trap_cause_reg <= REG_RESET;
            trap_data_addr <= REG_RESET;
        end
        else if (take_trap)
        begin
            trap_cause_reg <= {{(32 - PTU_NCAUSE){1'b0}}, win};
            trap_data_addr <= next_daddr;
        end
        else if (bus_wr)
        begin
            if (adr_i == OFS_CAUSE)
                trap_cause_reg <= (trap_cause_reg & ~wmask) | (dat_i & wmask);
            if (adr_i == OFS_DADDR)
                trap_data_addr <= (trap_data_addr & ~wmask) | (dat_i & wmask);
        end
    end

    // Software-only registers: handler entry and configuration.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            handler_entry_addr <= REG_RESET;
            config_reg <= REG_RESET;
        end
        else if (bus_wr)
        begin
            if (adr_i == OFS_HANDLER)
                handler_entry_addr <= ((handler_entry_addr & ~wmask) | (dat_i & wmask)) & PC_ALIGN_MASK;
            if (adr_i == OFS_CONFIG)
                config_reg[CFG_MISALIGN_OK] <= (config_reg[CFG_MISALIGN_OK] & ~sel_i[0])
                    | (dat_i[CFG_MISALIGN_OK] & sel_i[0]);
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave.
    // ------------------------------------------------------------

    // Read multiplexer; unmapped offsets read as zero.
    always_comb
    begin
        unique case (adr_i)
            OFS_STATUS: next_rdata = status;
            OFS_SAVED_SW: next_rdata = saved_status;
            OFS_SAVED_RESUME_ADDR: next_rdata = saved_resume_addr;
            OFS_OLDER_SW: next_rdata = older_status;
            OFS_OLDER_PC: next_rdata = older_resume_addr;
            OFS_HANDLER: next_rdata = handler_entry_addr;
            OFS_CAUSE: next_rdata = trap_cause_reg;
            OFS_DADDR: next_rdata = trap_data_addr;
            OFS_CONFIG: next_rdata = config_reg;
            default: next_rdata = REG_RESET;
        endcase
    end

    // Acknowledge one cycle after the strobe, data registered with it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= REG_RESET;
        end
        else
        begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (cyc_i && stb_i && !ack_o)
                dat_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_TRAP_REDIRECT: assert property (
        take_trap |=> redirect_o && redirect_addr_o == $past(handler_entry_addr))
        else $error("Trap did not redirect to handler entry.");

    AST_CAUSE_ONEHOT: assert property (
        take_trap |=> $onehot(trap_cause_reg))
        else $error("Cause register is not one-hot after trap.");

    AST_PRIO_TOP: assert property (
        take_trap && icache_bus_fault_i |=> trap_cause_reg[C_IC_BUS])
        else $error("Highest priority cause lost.");

    AST_IRQ_CAUSE: assert property (
        take_trap && ext_irq_i && status[SW_IRQ_EN] && !icache_bus_fault_i && !dcache_bus_fault_i
        |=> trap_cause_reg == 32'h0000_0004)
        else $error("External interrupt not recorded as bit two.");

    AST_STATUS_CLEAR: assert property (
        take_trap |=> (status & SW_TRAP_CLR) == REG_RESET && redirect_o)
        else $error("Status flags not cleared on trap entry.");

    AST_SAVE_STATE: assert property (
        take_trap |=> saved_status == $past(status)
            && saved_resume_addr == ($past(current_bundle_addr_i) & PC_ALIGN_MASK))
        else $error("Saved state wrong after trap.");

    AST_DADDR_ZERO: assert property (
        take_trap && !(|(win & DADDR_CAUSES)) |=> trap_data_addr == REG_RESET)
        else $error("Data address not zero for non-data cause.");

    AST_SQUASH: assert property (
        take_trap |=> !commit_o [*3])
        else $error("Younger bundle committed after trap.");

    AST_FAULT_CANCEL: assert property (
        bundle_valid_i && any_cause && !squash |-> !commit_o && cancel_o ##1 redirect_o)
        else $error("Faulting bundle committed or was not trapped.");

    AST_RFI_RESTORE: assert property (
        do_rfi |=> status == $past(saved_status) && redirect_addr_o == $past(saved_resume_addr)
            && saved_status == $past(older_status))
        else $error("Return from trap did not restore state.");
endmodule
`default_nettype wire

// ### ptu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ptu_core_model
    import ptu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [15:0] src_i,
    input wire logic rfi_i,
    input wire logic redirect_i,
    input wire logic [31:0] redirect_addr_i,
    input wire logic commit_i,
    output logic bundle_valid_o,
    output logic rfi_op_o,
    output logic [15:0] cause_o,
    output logic [31:0] pc_o
);
    // ------------------------------------------------------------
    // Bundle presentation
    // ------------------------------------------------------------
    // A bundle stands only while requested, so cause lines are low between bundles.
    assign bundle_valid_o = req_i;
    assign rfi_op_o = req_i & rfi_i;
    assign cause_o = req_i ? src_i : 16'h0000;

    // Fetch follows every redirect and otherwise steps past committed bundles.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pc_o <= 32'h0000_0100;
        else if (redirect_i)
            pc_o <= redirect_addr_i;
        else if (commit_i)
            pc_o <= pc_o + 32'h0000_0004;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ptu_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, rfi = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, daddr = 32'h0, rdat, raddr, status, pc, hnd, pre, da, prev_pc;
    logic [15:0] src = 16'h0, cause;
    logic ack, valid, rfi_op, commit, cancel, redirect;
    logic [31:0] q_rd[$], q_ra[$];
    logic [1:0] q_cc[$];
    int err_total = 0;
    int check_count = 0;
    int cb;

    // Half-period toggle gives the 25 ns core clock.
    always #12.5 clk_i = ~clk_i;

    ptu_trap_unit uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .bundle_valid_i(valid),
        .current_bundle_addr_i(pc), .rfi_op_i(rfi_op), .icache_bus_fault_i(cause[0]),
        .dcache_bus_fault_i(cause[1]), .ext_irq_i(cause[2]), .fetch_watch_hit_i(cause[3]),
        .fetch_region_miss_i(cause[4]), .fetch_perm_fault_i(cause[5]), .soft_bp_hit_i(cause[6]),
        .bad_bundle_i(cause[7]), .priv_op_i(cause[15]), .data_watch_hit_i(cause[8]),
        .misaligned_i(cause[9]), .ctlreg_unmapped_i(cause[10]), .ctlreg_store_i(cause[11]),
        .data_region_miss_i(cause[12]), .data_perm_fault_i(cause[13]), .side_iface_timeout_i(cause[14]),
        .data_addr_i(daddr), .commit_o(commit), .cancel_o(cancel), .redirect_o(redirect),
        .redirect_addr_o(raddr), .status_o(status));

    ptu_core_model core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .src_i(src), .rfi_i(rfi),
        .redirect_i(redirect), .redirect_addr_i(raddr), .commit_i(commit), .bundle_valid_o(valid),
        .rfi_op_o(rfi_op), .cause_o(cause), .pc_o(pc));

    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        check(q_ra.size(), 0);
        check(q_rd.size(), 0);
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    // One classic cycle; the request is held until the edge that samples ack high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(negedge clk_i);
        while (ack !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        q_rd.push_back(exp);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    // One bundle for one cycle, then one idle cycle.
    task automatic bun(input logic [15:0] s, input logic r, input logic [1:0] cc);
        q_cc.push_back(cc);
        req <= 1'b1;
        src <= s;
        rfi <= r;
        @(posedge clk_i);
        req <= 1'b0;
        src <= 16'h0;
        rfi <= 1'b0;
        @(posedge clk_i);
    endtask

    // Results are taken off the queues as they appear, at the settled half of the cycle.
    always @(negedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            check(rdat, q_rd.size() > 0 ? q_rd.pop_front() : 32'hdead_beef);
        if (redirect === 1'b1)
            check(raddr, q_ra.size() > 0 ? q_ra.pop_front() : 32'hdead_beef);
        if (valid === 1'b1)
            check({30'h0, commit, cancel}, {30'h0, q_cc.size() > 0 ? q_cc.pop_front() : 2'b11});
    end

    // Watchdog sized well above the expected run of some 550 cycles.
    initial
    begin
        #(25 * 8000);
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h2f41ad59));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a <= 36; a += 4)
            rd(a[7:0], 32'h0);
        wb(1'b1, 8'h24, 32'hffff_ffff, 4'hf);
        rd(8'h24, 32'h0);
        wb(1'b1, OFS_STATUS, 32'hffff_ffff, 4'h2);
        rd(OFS_STATUS, 32'h0000_1300);
        $display("test registers done");
        hnd = $urandom;
        wb(1'b1, OFS_HANDLER, hnd, 4'hf);
        hnd = hnd & 32'hffff_fffc;
        rd(OFS_HANDLER, hnd);
        prev_pc = 32'h0;
        // Each cause wins over random lower-priority companions; index 15 is a user privileged op.
        for (int i = 0; i < 16; i++)
        begin
            cb = (i == 15) ? 7 : i;
            bun(16'h0, 1'b0, 2'b10);
            wb(1'b1, OFS_STATUS, 32'h0000_0303, 4'hf);
            // The bundle before each later trap is the one at the handler entry; the first trap hits 0x104.
            pre = (i == 0) ? 32'h0000_0104 : hnd + 32'h0000_0004;
            da = $urandom;
            daddr <= da;
            q_ra.push_back(hnd);
            bun((16'h1 << i) | (16'($urandom) & ~((16'h2 << cb) - 16'h1) & 16'h7fff), 1'b0, 2'b01);
            if (i == 0)
                bun(16'h1 << C_SIDE_TO, 1'b0, 2'b01);
            rd(OFS_CAUSE, 32'h1 << cb);
            rd(OFS_DADDR, (cb >= 8 && cb <= 13) ? da : 32'h0);
            rd(OFS_SAVED_SW, 32'h0000_0303);
            rd(OFS_SAVED_RESUME_ADDR, pre);
            rd(OFS_OLDER_SW, (i == 0) ? 32'h0 : 32'h0000_0303);
            rd(OFS_OLDER_PC, prev_pc);
            rd(OFS_STATUS, 32'h0);
            check(status, 32'h0);
            prev_pc = pre;
        end
        $display("test causes done");
        // Disabled interrupt and supported misalignment commit without a trap.
        wb(1'b1, OFS_CONFIG, 32'h1, 4'hf);
        bun(16'h1 << C_EXT_INT, 1'b0, 2'b10);
        bun(16'h1 << C_MISALIGN, 1'b0, 2'b10);
        bun(16'h1 << C_CR_DENY, 1'b0, 2'b10);
        $display("test gating done");
        // Distinct older copies show that the return refills the saved pair from them.
        wb(1'b1, OFS_OLDER_PC, 32'h0000_0a50, 4'hf);
        wb(1'b1, OFS_OLDER_SW, 32'h0000_0001, 4'hf);
        q_ra.push_back(pre);
        bun(16'h0, 1'b1, 2'b10);
        rd(OFS_STATUS, 32'h0000_0303);
        check(status, 32'h0000_0303);
        rd(OFS_SAVED_RESUME_ADDR, 32'h0000_0a50);
        rd(OFS_SAVED_SW, 32'h0000_0001);
        $display("test return done");
        repeat (4) @(posedge clk_i);
        final_report();
    end
endmodule
`default_nettype wire
